// *** common/regbank_pkg.sv ***
/*
 * Register map constants for the amplifier gain, offset chop and
 * input source configuration bank: word indexes, reset values,
 * writable-bit masks, field positions and input source codes.
 * Assumes a 32-bit classic Wishbone slave, one register per word.
 */
package regbank_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADR_W = 8;           // byte address width
   localparam int DAT_W = 32;          // bus data width
   localparam int REG_W = 16;          // register width

   // ==========================================================
   // register indexes; byte address is four times the index
   localparam logic [5:0] GAIN_IDX = 6'h04;
   localparam logic [5:0] CHOP_IDX = 6'h06;
   localparam logic [5:0] CFG0_IDX = 6'h09;
   localparam logic [5:0] CFG1_IDX = 6'h0E;

   // ==========================================================
   // reset values
   localparam logic [15:0] GAIN_RST = 16'h0000;
   localparam logic [15:0] CHOP_RST = 16'h0600;
   localparam logic [15:0] CFG_RST  = 16'h0000;
   localparam logic [3:0]  CHOP_DLY_RST = 4'h3;

   // ==========================================================
   // writable bits; cleared bits are read-only zero
   localparam logic [15:0] GAIN_WMASK = 16'hFFFF;
   localparam logic [15:0] CHOP_WMASK = 16'hFFFF;
   localparam logic [15:0] CFG_WMASK  = 16'hFFC7;

   // ==========================================================
   // field positions
   localparam int GAIN_FLD_W   = 3;
   localparam int GAIN_CH_STEP = 4;    // one nibble per channel
   localparam int GAIN_CH0_LSB = 0;
   localparam int GAIN_CH1_LSB = 4;
   localparam int GAIN_CH2_LSB = 8;
   localparam int GAIN_CH3_LSB = 12;
   localparam int CHOP_EN_BIT  = 8;
   localparam int CHOP_DLY_LSB = 9;
   localparam int CHOP_DLY_W   = 4;
   localparam int SEL_LSB      = 0;
   localparam int SEL_W        = 2;
   localparam int FACTOR_W     = 8;    // gain 1..128 as one-hot

   // ==========================================================
   // input source codes
   localparam logic [1:0] SEL_NORMAL   = 2'h0;
   localparam logic [1:0] SEL_SHORTED  = 2'h1;
   localparam logic [1:0] SEL_POS_TEST = 2'h2;
   localparam logic [1:0] SEL_NEG_TEST = 2'h3;

endpackage : regbank_pkg

// *** hw/adc_gain_chop_input_config_regs.sv ***
/*
 * Configuration register bank for a four-channel converter: the
 * per-channel amplifier gain codes, the offset chop enable and
 * delay, and the input source selection of channels 0 and 1.
 * Assumes a classic Wishbone master on the same clock as the bank
 * and a converter datapath that consumes the decoded outputs.
 */
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: gain register at 04h, resets 0000h
// RULE2: gain bits 14:12 set channel 3 gain
// RULE3: gain bits 10:8 set channel 2 gain
// RULE4: gain bits 6:4 set channel 1 gain
// RULE5: gain bits 2:0 set channel 0 gain
// RULE6: chop register 06h, delay 12:9, enable 8
// RULE7: channel 0 config at 09h, resets 0000h
// RULE8: channel 0 bits 1:0 pick input source
// RULE9: channel 1 config at 0Eh, resets 0000h
// RULE10: channel 1 bits 1:0 pick input source
// RULE11: config bits 5:3 read zero, write ignored
// RULE12: chop delay stored, passed on uninterpreted
module adc_gain_chop_input_config_regs (
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic [3:0]  i_wb_sel,
   output logic             o_wb_ack,
   output logic      [31:0] o_wb_dat,
   output logic      [2:0]  o_amp_gain_ch0,
   output logic      [2:0]  o_amp_gain_ch1,
   output logic      [2:0]  o_amp_gain_ch2,
   output logic      [2:0]  o_amp_gain_ch3,
   output logic      [31:0] o_amp_gain_factor,
   output logic             o_chop_enable,
   output logic      [3:0]  o_chop_delay,
   output logic      [1:0]  o_input_select_ch0,
   output logic      [1:0]  o_input_select_ch1
);

   // ==========================================================
   // state

   // the whole bank state lives in one record
   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      logic [15:0] gain;
      logic [15:0] chop;
      logic [15:0] cfg0;
      logic [15:0] cfg1;
   } state_t;

   localparam state_t ST_RST = '{
      ack:  1'b0,
      rdat: 32'h0000_0000,
      gain: regbank_pkg::GAIN_RST,
      chop: regbank_pkg::CHOP_RST,
      cfg0: regbank_pkg::CFG_RST,
      cfg1: regbank_pkg::CFG_RST
   };

   state_t      st_q;
   state_t      st_d;
   logic        req;
   logic        wr_fire;
   logic [5:0]  idx;
   logic        hit_gain;
   logic        hit_chop;
   logic        hit_cfg0;
   logic        hit_cfg1;
   logic [15:0] lanes;
   logic [15:0] rd_val;

   // ==========================================================
   // bus decode

   // address bits 1:0 are ignored, every register is word aligned
   assign req      = i_wb_cyc & i_wb_stb;
   assign idx      = i_wb_adr[7:2];
   assign hit_gain = (idx == regbank_pkg::GAIN_IDX); // RULE1
   assign hit_chop = (idx == regbank_pkg::CHOP_IDX); // RULE6
   assign hit_cfg0 = (idx == regbank_pkg::CFG0_IDX); // RULE7
   assign hit_cfg1 = (idx == regbank_pkg::CFG1_IDX); // RULE9
   // only lanes 0 and 1 carry register bits
   assign lanes    = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
   // writes land on the edge where the master sees ack high
   assign wr_fire  = req & i_wb_we & st_q.ack;

   // read mux; unmapped words read as zero
   always_comb begin
      rd_val = 16'h0000;
      if (hit_gain) begin
         rd_val = st_q.gain;
      end else if (hit_chop) begin
         rd_val = st_q.chop;
      end else if (hit_cfg0) begin
         rd_val = st_q.cfg0 & regbank_pkg::CFG_WMASK; // RULE11
      end else if (hit_cfg1) begin
         rd_val = st_q.cfg1 & regbank_pkg::CFG_WMASK; // RULE11
      end
   end

   // merge write data under byte lanes and the writable mask
   function automatic logic [15:0] merge(
      input logic [15:0] old_v,
      input logic [15:0] new_v,
      input logic [15:0] lane_m,
      input logic [15:0] wr_m
   );
      logic [15:0] m;
      m = lane_m & wr_m;
      return (old_v & ~m) | (new_v & m);
   endfunction : merge

   // ==========================================================
   // next state

   // ack rises one cycle after the request and falls after one
   // cycle, so a request still held is acked again every second cycle
   always_comb begin
      st_d     = st_q;
      st_d.ack = req & ~st_q.ack;
      if (req & ~st_q.ack) begin
         st_d.rdat = {16'h0000, rd_val};
      end
      if (wr_fire) begin
         if (hit_gain) begin
            st_d.gain = merge(st_q.gain, i_wb_dat[15:0], lanes,
                              regbank_pkg::GAIN_WMASK); // RULE2
         end
         if (hit_chop) begin
            st_d.chop = merge(st_q.chop, i_wb_dat[15:0], lanes,
                              regbank_pkg::CHOP_WMASK); // RULE6
         end
         if (hit_cfg0) begin
            st_d.cfg0 = merge(st_q.cfg0, i_wb_dat[15:0], lanes,
                              regbank_pkg::CFG_WMASK); // RULE8
         end
         if (hit_cfg1) begin
            st_d.cfg1 = merge(st_q.cfg1, i_wb_dat[15:0], lanes,
                              regbank_pkg::CFG_WMASK); // RULE10
         end
      end
   end

   // state register; reset loads constants only
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= ST_RST; // RULE1
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // outputs

   // bus answer
   assign o_wb_ack = st_q.ack;
   assign o_wb_dat = st_q.rdat;

   // raw gain codes for the amplifier control
   assign o_amp_gain_ch0 = st_q.gain[regbank_pkg::GAIN_CH0_LSB +: regbank_pkg::GAIN_FLD_W]; // RULE5
   assign o_amp_gain_ch1 = st_q.gain[regbank_pkg::GAIN_CH1_LSB +: regbank_pkg::GAIN_FLD_W]; // RULE4
   assign o_amp_gain_ch2 = st_q.gain[regbank_pkg::GAIN_CH2_LSB +: regbank_pkg::GAIN_FLD_W]; // RULE3
   assign o_amp_gain_ch3 = st_q.gain[regbank_pkg::GAIN_CH3_LSB +: regbank_pkg::GAIN_FLD_W]; // RULE2

   // gain factor 1..128 as a one-hot byte per channel
   for (genvar c = 0; c < 4; c++) begin : g_factor
      assign o_amp_gain_factor[c*regbank_pkg::FACTOR_W +: regbank_pkg::FACTOR_W] =
         8'h01 << st_q.gain[c*regbank_pkg::GAIN_CH_STEP +: regbank_pkg::GAIN_FLD_W]; // RULE2
   end

   // chop delay is a raw value; its timing lives downstream
   assign o_chop_enable = st_q.chop[regbank_pkg::CHOP_EN_BIT]; // RULE6
   assign o_chop_delay  = st_q.chop[regbank_pkg::CHOP_DLY_LSB +: regbank_pkg::CHOP_DLY_W]; // RULE12

   // input source codes, see SEL_* in the package
   assign o_input_select_ch0 = st_q.cfg0[regbank_pkg::SEL_LSB +: regbank_pkg::SEL_W]; // RULE8
   assign o_input_select_ch1 = st_q.cfg1[regbank_pkg::SEL_LSB +: regbank_pkg::SEL_W]; // RULE10

   // ==========================================================
   // checks

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   // ack is a single cycle pulse
   AST_ACK_PULSE: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held for more than one cycle");

   // every fresh request is answered on the next edge
   AST_ACK_NEXT: assert property (
      (req && !o_wb_ack) |=> o_wb_ack)
      else $error("request not answered in one cycle");

   // no answer without a request
   AST_ACK_CAUSE: assert property (
      o_wb_ack |-> $past(req))
      else $error("ack without request");

   // reset values seen at release
   AST_GAIN_RST: assert property ( // RULE1
      $rose(i_resetn) |-> o_amp_gain_factor == 32'h0101_0101)
      else $error("gains not unity after reset");

   AST_CHOP_RST: assert property ( // RULE6
      $rose(i_resetn) |-> (!o_chop_enable && o_chop_delay == 4'h3))
      else $error("chop register reset value wrong");

   AST_CFG0_RST: assert property ( // RULE7
      $rose(i_resetn) |-> o_input_select_ch0 == 2'h0)
      else $error("channel 0 source not normal after reset");

   AST_CFG1_RST: assert property ( // RULE9
      $rose(i_resetn) |-> o_input_select_ch1 == 2'h0)
      else $error("channel 1 source not normal after reset");

   // gain fields follow a write of their own lane
   AST_GAIN_CH3: assert property ( // RULE2
      (wr_fire && hit_gain && i_wb_sel[1])
      |=> o_amp_gain_ch3 == $past(i_wb_dat[14:12]))
      else $error("channel 3 gain not written");

   AST_GAIN_CH2: assert property ( // RULE3
      (wr_fire && hit_gain && i_wb_sel[1])
      |=> o_amp_gain_factor[23:16] == (8'h01 << $past(i_wb_dat[10:8])))
      else $error("channel 2 gain factor wrong");

   AST_GAIN_CH1: assert property ( // RULE4
      (wr_fire && hit_gain && i_wb_sel[0])
      |=> o_amp_gain_ch1 == $past(i_wb_dat[6:4]))
      else $error("channel 1 gain not written");

   AST_GAIN_CH0: assert property ( // RULE5
      (wr_fire && hit_gain && i_wb_sel[0])
      |=> o_amp_gain_ch0 == $past(i_wb_dat[2:0]))
      else $error("channel 0 gain not written");

   AST_CHOP_WR: assert property ( // RULE6
      (wr_fire && hit_chop && i_wb_sel[1])
      |=> (o_chop_enable == $past(i_wb_dat[8]) &&
           o_chop_delay == $past(i_wb_dat[12:9])))
      else $error("chop fields not written");

   AST_SEL0_WR: assert property ( // RULE8
      (wr_fire && hit_cfg0 && i_wb_sel[0])
      |=> o_input_select_ch0 == $past(i_wb_dat[1:0]))
      else $error("channel 0 source not written");

   AST_SEL1_WR: assert property ( // RULE10
      (wr_fire && hit_cfg1 && i_wb_sel[0])
      |=> o_input_select_ch1 == $past(i_wb_dat[1:0]))
      else $error("channel 1 source not written");

   // read-only config bits and the upper half read zero
   AST_CFG_RO: assert property ( // RULE11
      (o_wb_ack && (hit_cfg0 || hit_cfg1))
      |-> (o_wb_dat[5:3] == 3'h0 && o_wb_dat[31:16] == 16'h0000))
      else $error("reserved config bits read nonzero");

   // delay only moves on a chop write
   AST_DLY_HOLD: assert property ( // RULE12
      !(wr_fire && hit_chop) |=> $stable(o_chop_delay))
      else $error("chop delay changed without a write");

   // enable only moves on a chop write
   AST_EN_HOLD: assert property ( // RULE6
      !(wr_fire && hit_chop) |=> $stable(o_chop_enable))
      else $error("chop enable changed without a write");

   // gain codes only move on a gain write
   AST_GAIN_HOLD: assert property ( // RULE2
      !(wr_fire && hit_gain) |=> $stable(o_amp_gain_factor))
      else $error("gain changed without a write");

   // a lower lane write must leave channels 3 and 2 alone
   AST_GAIN_LANE: assert property ( // RULE3
      (wr_fire && hit_gain && !i_wb_sel[1])
      |=> ($stable(o_amp_gain_ch3) && $stable(o_amp_gain_ch2)))
      else $error("upper gain codes moved on a lower lane write");

   // source codes only move on a config write
   AST_SEL_HOLD: assert property ( // RULE8
      !(wr_fire && (hit_cfg0 || hit_cfg1))
      |=> ($stable(o_input_select_ch0) && $stable(o_input_select_ch1)))
      else $error("input source changed without a write");

   // ==========================================================
   // read-back checks: the captured word must agree with the
   // outputs, so a swapped leg of the read mux shows up here

   AST_RD_GAIN: assert property ( // RULE1
      (o_wb_ack && !i_wb_we && hit_gain)
      |-> (o_wb_dat[regbank_pkg::GAIN_CH0_LSB +: regbank_pkg::GAIN_FLD_W] == o_amp_gain_ch0 &&
           o_wb_dat[regbank_pkg::GAIN_CH1_LSB +: regbank_pkg::GAIN_FLD_W] == o_amp_gain_ch1 &&
           o_wb_dat[regbank_pkg::GAIN_CH2_LSB +: regbank_pkg::GAIN_FLD_W] == o_amp_gain_ch2 &&
           o_wb_dat[regbank_pkg::GAIN_CH3_LSB +: regbank_pkg::GAIN_FLD_W] == o_amp_gain_ch3))
      else $error("gain read-back differs from gain outputs");

   AST_RD_CHOP: assert property ( // RULE6
      (o_wb_ack && !i_wb_we && hit_chop)
      |-> (o_wb_dat[regbank_pkg::CHOP_EN_BIT] == o_chop_enable &&
           o_wb_dat[regbank_pkg::CHOP_DLY_LSB +: regbank_pkg::CHOP_DLY_W] == o_chop_delay))
      else $error("chop read-back differs from chop outputs");

   AST_RD_SEL0: assert property ( // RULE8
      (o_wb_ack && !i_wb_we && hit_cfg0)
      |-> o_wb_dat[regbank_pkg::SEL_LSB +: regbank_pkg::SEL_W] == o_input_select_ch0)
      else $error("channel 0 source read-back wrong");

   AST_RD_SEL1: assert property ( // RULE10
      (o_wb_ack && !i_wb_we && hit_cfg1)
      |-> o_wb_dat[regbank_pkg::SEL_LSB +: regbank_pkg::SEL_W] == o_input_select_ch1)
      else $error("channel 1 source read-back wrong");

   // unmapped words read zero and swallow writes
   AST_RD_UNMAPPED: assert property (
      (o_wb_ack && !i_wb_we && !(hit_gain || hit_chop || hit_cfg0 || hit_cfg1))
      |-> o_wb_dat == 32'h0000_0000)
      else $error("unmapped word read nonzero");

   AST_WR_UNMAPPED: assert property (
      (wr_fire && !(hit_gain || hit_chop || hit_cfg0 || hit_cfg1))
      |=> ($stable(o_amp_gain_factor) && $stable(o_chop_enable) &&
           $stable(o_chop_delay) && $stable(o_input_select_ch0) &&
           $stable(o_input_select_ch1)))
      else $error("unmapped write changed a register");

   COV_GAIN_WR: cover property (
      wr_fire && hit_gain && i_wb_sel == 4'hF);
   COV_CHOP_ON: cover property (
      $rose(o_chop_enable));
   COV_CFG1_RD: cover property (
      o_wb_ack && hit_cfg1 && !i_wb_we);
   COV_UNMAPPED: cover property (
      o_wb_ack && !(hit_gain || hit_chop || hit_cfg0 || hit_cfg1));
   COV_SEL_NEG: cover property (
      o_input_select_ch0 == regbank_pkg::SEL_NEG_TEST);

endmodule : adc_gain_chop_input_config_regs

// *** verification/test_adc_gain_chop_input_config_regs.sv ***
/*
 * Self-checking bench for the gain, chop and input source register bank:
 * reset values, every gain and source code, byte lanes, read-only bits,
 * unmapped access, random traffic and a second reset in mid-run.
 * Assumes the bank answers each classic Wishbone request with one ack pulse.
 */
`timescale 1ns/1ps

module test_adc_gain_chop_input_config_regs;
   logic        i_clock;
   logic        i_resetn;
   logic        i_wb_cyc;
   logic        i_wb_stb;
   logic        i_wb_we;
   logic [7:0]  i_wb_adr;
   logic [31:0] i_wb_dat;
   logic [3:0]  i_wb_sel;
   logic        o_wb_ack;
   logic [31:0] o_wb_dat;
   logic [2:0]  o_amp_gain_ch0;
   logic [2:0]  o_amp_gain_ch1;
   logic [2:0]  o_amp_gain_ch2;
   logic [2:0]  o_amp_gain_ch3;
   logic [31:0] o_amp_gain_factor;
   logic        o_chop_enable;
   logic [3:0]  o_chop_delay;
   logic [1:0]  o_input_select_ch0;
   logic [1:0]  o_input_select_ch1;
   int          miscompares;
   int          samples_checked;
   logic [15:0] shadow [4];
   logic [15:0] dat;
   // last entry is an unmapped word, expected to read zero
   localparam logic [7:0] ADDRS [5] = '{8'h10, 8'h18, 8'h24, 8'h38, 8'h3C};

   adc_gain_chop_input_config_regs adc_gain_chop_input_config_regs_inst (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
      .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .o_amp_gain_ch0(o_amp_gain_ch0),
      .o_amp_gain_ch1(o_amp_gain_ch1), .o_amp_gain_ch2(o_amp_gain_ch2),
      .o_amp_gain_ch3(o_amp_gain_ch3), .o_amp_gain_factor(o_amp_gain_factor),
      .o_chop_enable(o_chop_enable), .o_chop_delay(o_chop_delay),
      .o_input_select_ch0(o_input_select_ch0), .o_input_select_ch1(o_input_select_ch1));

   // 250 MHz
   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end

   // ==========================================================
   // reference model and helpers
   task automatic reset_model();
      shadow = '{regbank_pkg::GAIN_RST, regbank_pkg::CHOP_RST, regbank_pkg::CFG_RST, regbank_pkg::CFG_RST};
   endtask : reset_model

   function automatic logic [15:0] wmask(input int k);
      return (k >= 2) ? regbank_pkg::CFG_WMASK : (k == 0 ? regbank_pkg::GAIN_WMASK : regbank_pkg::CHOP_WMASK);
   endfunction : wmask

   // gain code n means gain 2**n, one-hot in each channel byte
   function automatic logic [31:0] factor(input logic [15:0] g);
      logic [31:0] f;
      for (int c = 0; c < 4; c++) f[c*8 +: 8] = 8'h01 << g[c*4 +: 3];
      return f;
   endfunction : factor

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // ==========================================================
   // classic single cycle; held until ack is sampled, bounded wait
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     input logic [3:0] sel, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge i_clock);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= we;
      i_wb_adr <= adr;
      i_wb_dat <= wd;
      i_wb_sel <= sel;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 40);
      r = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      if (o_wb_ack !== 1'b1) begin
         miscompares++;
         stop_test();
      end
      check(32'(n), 32'h2);
   endtask : wb

   // outputs change on the write edge and are sampled one cycle later
   task automatic check_outputs();
      @(posedge i_clock);
      #1;
      check(32'(o_amp_gain_ch0), 32'(shadow[0][2:0]));
      check(32'(o_amp_gain_ch1), 32'(shadow[0][6:4]));
      check(32'(o_amp_gain_ch2), 32'(shadow[0][10:8]));
      check(32'(o_amp_gain_ch3), 32'(shadow[0][14:12]));
      check(o_amp_gain_factor, factor(shadow[0]));
      check(32'(o_chop_enable), 32'(shadow[1][8]));
      check(32'(o_chop_delay), 32'(shadow[1][12:9]));
      check(32'(o_input_select_ch0), 32'(shadow[2][1:0]));
      check(32'(o_input_select_ch1), 32'(shadow[3][1:0]));
   endtask : check_outputs

   // address low bits and upper data half are junk on purpose: both are ignored
   task automatic access(input int k, input logic we, input logic [15:0] wd, input logic [3:0] sel);
      logic [15:0] lm;
      logic [31:0] r;
      lm = {{8{sel[1]}}, {8{sel[0]}}};
      wb(we, ADDRS[k] | 8'($urandom % 4), {16'($urandom), wd}, sel, r);
      if (!we) check(r, {16'h0000, (k < 4) ? shadow[k] : 16'h0000});
      else if (k < 4) shadow[k] = ((shadow[k] & ~lm) | (wd & lm)) & wmask(k);
      check_outputs();
   endtask : access

   task automatic read_all(input string name);
      for (int k = 0; k < 5; k++) access(k, 1'b0, 16'h0000, 4'h0);
      $display("test %s done", name);
   endtask : read_all

   // ==========================================================
   // main sequence
   initial begin
      i_resetn = 1'b0;
      i_wb_cyc = 1'b0;
      i_wb_stb = 1'b0;
      i_wb_we = 1'b0;
      i_wb_adr = 8'h00;
      i_wb_dat = 32'h0000_0000;
      i_wb_sel = 4'h0;
      miscompares = 0;
      samples_checked = 0;
      void'($urandom(27455));
      reset_model();
      repeat (8) @(posedge i_clock);
      i_resetn <= 1'b1;
      read_all("reset_values");
      // every code on every channel, channels staggered so a swap shows
      for (int c = 0; c < 8; c++) begin
         for (int ch = 0; ch < 4; ch++) dat[ch*4 +: 4] = {1'b0, 3'(c + ch)};
         access(0, 1'b1, dat, 4'h3);
         access(0, 1'b0, 16'h0000, 4'h0);
      end
      $display("test gain_codes done");
      // all source codes, with the read-only bits written as ones
      for (int s = 0; s < 4; s++) begin
         access(2, 1'b1, 16'hFFFC | 16'(s), 4'h3);
         access(3, 1'b1, 16'hFFFC | 16'(3 - s), 4'h3);
         access(2, 1'b0, 16'h0000, 4'h0);
         access(3, 1'b0, 16'h0000, 4'h0);
      end
      $display("test input_select done");
      // one lane at a time: upper lane sets chop enable and maximum delay, then lower lane alone
      access(1, 1'b1, 16'h1FFF, 4'h2);
      access(1, 1'b1, 16'h00A5, 4'h1);
      access(4, 1'b1, 16'hFFFF, 4'hF);
      read_all("lanes_unmapped");
      repeat (120) access(int'($urandom % 5), 1'($urandom), 16'($urandom), 4'($urandom));
      read_all("random");
      // second reset in mid-run restores every reset value
      @(posedge i_clock);
      i_resetn <= 1'b0;
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      reset_model();
      read_all("second_reset");
      stop_test();
   end
endmodule : test_adc_gain_chop_input_config_regs
